// ---- rtl/dfr_diag_flags.sv ----
`timescale 1ns/100ps
// Summary of operation
// - diag_word low/mid bytes read-only at 0x08/0x09
// - bit0 low: supply power-on; reset 0000_0011
// - bit1 low: output undervoltage, clear on read
// - bit2 low: over-temperature reset, clear on read
// - bit3 low: over-temperature warning, clear on read
// - bit4 low: battery overvoltage; bit5 reserved
// - bit6 low: LIN remote wakeup, clear on read
// - bit7 low: window watchdog failure, clear on read
// - bit0 mid: transmit low over one second
// - bit1 mid: temporary thermal shutdown entered
// - bit2 mid: standby timeout watchdog failure
// - bit3 mid: load dump; 7:4 reserved, reset zero
module dfr_diag_flags #(
  parameter logic [dfr_pkg::TX_CNT_W-1:0] TX_STUCK_CYCLES =
    dfr_pkg::TX_CNT_W'(dfr_pkg::TX_STUCK_CYC)
) (
  input  wire logic              CLK,       // 100 MHz clock
  input  wire logic              ARST_N,    // async reset, active low
  input  wire logic              CE,        // clock enable, freezes all state
  input  wire dfr_pkg::dfr_evt_t EVT,       // asynchronous event levels
  input  wire logic              LIN_TX,    // transmit input pin, async
  input  wire logic              RD_EN,     // read strobe from serial port
  input  wire logic [7:0]        RD_ADDR,   // read address
  output logic [7:0]             RD_DATA,   // registered read data
  output logic                   RD_VALID   // one-cycle read answer
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  dfr_pkg::dfr_evt_t evt_meta_q;
  dfr_pkg::dfr_evt_t evt_q;
  logic              tx_meta_q;
  logic              tx_q;

  // analog levels are unrelated to CLK, two flops before use
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      evt_meta_q <= '0;
      evt_q      <= '0;
      tx_meta_q  <= 1'b1;
      tx_q       <= 1'b1;
    end
    else if (CE)
    begin
      evt_meta_q <= EVT;
      evt_q      <= evt_meta_q;
      tx_meta_q  <= LIN_TX;
      tx_q       <= tx_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // transmit-stuck timer
  // ---------------------------------------------------------------
  logic [dfr_pkg::TX_CNT_W-1:0] tx_cnt_q;
  logic [dfr_pkg::TX_CNT_W-1:0] tx_cnt_d;
  logic                         tx_stuck;

  // saturates so a dominant line keeps the event asserted
  assign tx_stuck = (tx_cnt_q >= TX_STUCK_CYCLES);
  assign tx_cnt_d = tx_q     ? '0 :
                    tx_stuck ? tx_cnt_q :
                               tx_cnt_q + 1'b1;

  // counts cycles while the synchronised pin is low
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      tx_cnt_q <= '0;
    else if (CE)
      tx_cnt_q <= tx_cnt_d;
  end

  // ---------------------------------------------------------------
  // read decode and flag update
  // ---------------------------------------------------------------
  logic [7:0] low_q;
  logic [7:0] low_d;
  logic [7:0] mid_q;
  logic [7:0] mid_d;
  logic [7:0] low_set;
  logic [7:0] mid_set;
  logic       rd_low;
  logic       rd_mid;
  logic [7:0] rd_mux;

  // strobe plus address match, shared by both byte selects
  function automatic logic addr_hit(input logic       en,
                                    input logic [7:0] addr,
                                    input logic [7:0] reg_addr);
    return en && (addr == reg_addr);
  endfunction : addr_hit

  assign rd_low = addr_hit(RD_EN, RD_ADDR, dfr_pkg::DIAG_LOW_ADDR);
  assign rd_mid = addr_hit(RD_EN, RD_ADDR, dfr_pkg::DIAG_MID_ADDR);

  // event map into the low byte, bit 5 never set
  assign low_set[dfr_pkg::LOW_POR] = evt_q.supply_power_on;
  assign low_set[dfr_pkg::LOW_UV]  = evt_q.output_undervoltage;
  assign low_set[dfr_pkg::LOW_OTR] = evt_q.overtemp_reset;
  assign low_set[dfr_pkg::LOW_OTW] = evt_q.overtemp_warning;
  assign low_set[dfr_pkg::LOW_OVV] = evt_q.battery_overvoltage;
  assign low_set[5]                = 1'b0;
  assign low_set[dfr_pkg::LOW_RWK] = evt_q.remote_wake;
  assign low_set[dfr_pkg::LOW_WWD] = evt_q.window_wd_fail;

  // event map into the mid byte, upper nibble never set
  assign mid_set[dfr_pkg::MID_TXS] = tx_stuck;
  assign mid_set[dfr_pkg::MID_TSD] = evt_q.thermal_shutdown;
  assign mid_set[dfr_pkg::MID_SWD] = evt_q.standby_wd_fail;
  assign mid_set[dfr_pkg::MID_LD]  = evt_q.load_dump;
  assign mid_set[7:4]              = 4'h0;

  // set wins over the read clear so no event is lost
  assign low_d = (rd_low ? 8'h00 : low_q) | low_set;
  assign mid_d = (rd_mid ? 8'h00 : mid_q) | mid_set;

  assign rd_mux = rd_low ? low_q :
                  rd_mid ? mid_q :
                           dfr_pkg::UNMAPPED_DATA;

  // sticky flags, read returns the value before clearing
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      low_q <= dfr_pkg::DIAG_LOW_RST;
      mid_q <= dfr_pkg::DIAG_MID_RST;
    end
    else if (CE)
    begin
      low_q <= low_d;
      mid_q <= mid_d;
    end
  end

  // read answer, one cycle after the strobe
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      RD_DATA  <= 8'h00;
      RD_VALID <= 1'b0;
    end
    else if (CE)
    begin
      RD_DATA  <= rd_mux;
      RD_VALID <= RD_EN;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // all checks live on CLK; reset masks them so no $past sees reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // low byte answer is the value before the clearing read
  AST_RD_LOW: assert property (
    CE && rd_low |=> RD_VALID && RD_DATA == $past(low_q))
    else $error("low byte read data wrong");

  // mid byte answer is the value before the clearing read
  AST_RD_MID: assert property (
    CE && rd_mid |=> RD_VALID && RD_DATA == $past(mid_q))
    else $error("mid byte read data wrong");

  // other addresses answer the fixed value and clear nothing
  AST_UNMAPPED: assert property (
    CE && RD_EN && !rd_low && !rd_mid |=> RD_DATA == dfr_pkg::UNMAPPED_DATA &&
      low_q == ($past(low_q) | $past(low_set)) && mid_q == ($past(mid_q) | $past(mid_set)))
    else $error("unmapped read wrong");

  // every strobe gets exactly one answer pulse
  AST_VALID: assert property (
    CE |=> RD_VALID == $past(RD_EN))
    else $error("read answer pulse wrong");

  // supply power-on event latches bit 0
  AST_POR: assert property (
    CE && evt_q.supply_power_on |=> low_q[dfr_pkg::LOW_POR])
    else $error("power-on flag not set");

  // output undervoltage event latches bit 1
  AST_UV: assert property (
    CE && evt_q.output_undervoltage |=> low_q[dfr_pkg::LOW_UV])
    else $error("undervoltage flag not set");

  // over-temperature reset event latches bit 2
  AST_OTR: assert property (
    CE && evt_q.overtemp_reset |=> low_q[dfr_pkg::LOW_OTR])
    else $error("overtemp reset flag not set");

  // over-temperature warning event latches bit 3
  AST_OTW: assert property (
    CE && evt_q.overtemp_warning |=> low_q[dfr_pkg::LOW_OTW])
    else $error("overtemp warning flag not set");

  // battery overvoltage event latches bit 4
  AST_OVV: assert property (
    CE && evt_q.battery_overvoltage |=> low_q[dfr_pkg::LOW_OVV])
    else $error("overvoltage flag not set");

  // reserved bits never read back as one
  AST_RESV: assert property (
    (low_q & dfr_pkg::DIAG_LOW_RESV) == 8'h00 && (mid_q & dfr_pkg::DIAG_MID_RESV) == 8'h00)
    else $error("reserved bit set");

  // remote wake event latches bit 6
  AST_RWK_SET: assert property (
    CE && evt_q.remote_wake |=> low_q[dfr_pkg::LOW_RWK])
    else $error("remote wake flag not set");

  // a latched remote wake reaches the host on a low byte read in the next cycle
  AST_RWK: assert property (
    CE && evt_q.remote_wake ##1 CE && rd_low |=> RD_DATA[dfr_pkg::LOW_RWK])
    else $error("remote wake not reported");

  // window watchdog failure latches bit 7
  AST_WWD: assert property (
    CE && evt_q.window_wd_fail |=> low_q[dfr_pkg::LOW_WWD])
    else $error("window watchdog flag not set");

  // saturated transmit timer latches mid bit 0
  AST_TXS: assert property (
    CE && tx_stuck |=> mid_q[dfr_pkg::MID_TXS])
    else $error("transmit stuck flag not set");

  // a released pin restarts the transmit timer
  AST_TX_CLR: assert property (
    CE && tx_q |=> tx_cnt_q == '0)
    else $error("transmit timer not restarted");

  // thermal shutdown entry latches mid bit 1
  AST_TSD: assert property (
    CE && evt_q.thermal_shutdown |=> mid_q[dfr_pkg::MID_TSD])
    else $error("thermal shutdown flag not set");

  // standby watchdog failure latches mid bit 2
  AST_SWD: assert property (
    CE && evt_q.standby_wd_fail |=> mid_q[dfr_pkg::MID_SWD])
    else $error("standby watchdog flag not set");

  // load dump latches mid bit 3
  AST_LD: assert property (
    CE && evt_q.load_dump |=> mid_q[dfr_pkg::MID_LD])
    else $error("load dump flag not set");

  // no flag drops while neither byte is read
  AST_HOLD: assert property (
    CE && !rd_low && !rd_mid |=>
      ((low_q & $past(low_q)) == $past(low_q)) &&
      ((mid_q & $past(mid_q)) == $past(mid_q)))
    else $error("flag lost without read");

  // a quiet low byte is empty after its read
  AST_CLR: assert property (
    CE && rd_low && low_set == 8'h00 |=> low_q == 8'h00)
    else $error("low byte not cleared by read");

  // a quiet mid byte is empty after its read
  AST_MID_CLR: assert property (
    CE && rd_mid && mid_set == 8'h00 |=> mid_q == 8'h00)
    else $error("mid byte not cleared by read");

  // power-on event in the low byte clearing cycle keeps its flag
  AST_SET_WINS: assert property (
    CE && rd_low && low_set[dfr_pkg::LOW_POR] |=> low_q[dfr_pkg::LOW_POR])
    else $error("read clear beat a live event");

  // low clock enable freezes flags, timer and read answer
  AST_FREEZE: assert property (
    !CE |=> $stable(low_q) && $stable(mid_q) && $stable(tx_cnt_q) &&
      $stable(RD_DATA) && $stable(RD_VALID))
    else $error("state moved with clock enable low");

  // ---------------------------------------------------------------
  // coverage of the main scenarios
  // ---------------------------------------------------------------
  // a read that empties a populated byte
  COV_READ_CLEAR: cover property (CE && rd_low && low_q != 8'h00 ##1 low_q == 8'h00);

  // an event lands in the very cycle of its read
  COV_SET_ON_READ: cover property (CE && rd_mid && mid_set != 8'h00);

  // the transmit timer runs out and latches
  COV_TX_STUCK: cover property (CE && tx_stuck ##1 mid_q[dfr_pkg::MID_TXS]);

  // a read outside the two bytes
  COV_UNMAPPED: cover property (CE && RD_EN && !rd_low && !rd_mid);

  // a held event survives the low byte read
  COV_HELD: cover property (CE && rd_low && low_set != 8'h00);

endmodule : dfr_diag_flags

// ---- rtl/dfr_pkg.sv ----
package dfr_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] DIAG_LOW_ADDR  = 8'h08;  // diag_word[7:0]
  localparam logic [7:0] DIAG_MID_ADDR  = 8'h09;  // diag_word[15:8]
  localparam logic [7:0] DIAG_LOW_RST   = 8'h03;  // power-on value of low byte
  localparam logic [7:0] DIAG_MID_RST   = 8'h00;  // power-on value of mid byte
  localparam logic [7:0] DIAG_LOW_RESV  = 8'h20;  // reserved bit 5
  localparam logic [7:0] DIAG_MID_RESV  = 8'hf0;  // reserved bits 7:4
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;  // answer to any other address

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LOW_POR  = 0;  // supply_power_on_flag
  localparam int LOW_UV   = 1;  // output_undervoltage_flag
  localparam int LOW_OTR  = 2;  // overtemp_reset_flag
  localparam int LOW_OTW  = 3;  // overtemp_warning_flag
  localparam int LOW_OVV  = 4;  // battery_overvoltage_flag
  localparam int LOW_RWK  = 6;  // remote_wake_flag
  localparam int LOW_WWD  = 7;  // window watchdog failure
  localparam int MID_TXS  = 0;  // transmit_stuck_flag
  localparam int MID_TSD  = 1;  // thermal_shutdown_flag
  localparam int MID_SWD  = 2;  // standby timeout watchdog failure
  localparam int MID_LD   = 3;  // load dump

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned TX_STUCK_S  = 1;            // transmit low limit, seconds
  localparam int unsigned CLK_HZ      = 100_000_000;  // CLK rate
  localparam int unsigned TX_STUCK_CYC = TX_STUCK_S * CLK_HZ;
  localparam int          TX_CNT_W    = 27;

  // ---------------------------------------------------------------
  // supervisory event levels from the analog side
  // ---------------------------------------------------------------
  typedef struct packed {
    logic load_dump;
    logic standby_wd_fail;
    logic thermal_shutdown;
    logic window_wd_fail;
    logic remote_wake;
    logic battery_overvoltage;
    logic overtemp_warning;
    logic overtemp_reset;
    logic output_undervoltage;
    logic supply_power_on;
  } dfr_evt_t;

endpackage : dfr_pkg

// ---- sim/dfr_diag_flags_test.sv ----
`timescale 1ns/100ps
// ---------------------------
// flag bank bench
// ---------------------------
module dfr_diag_flags_test;
  logic               clk, arst_n, ce, lin_tx, rd_en, rd_valid;
  logic [7:0]         rd_addr, rd_data, a;
  dfr_pkg::dfr_evt_t  evt, e;
  integer             seed, fails, check_count, i;

  dfr_diag_flags #(.TX_STUCK_CYCLES(27'd20)) dut (.CLK(clk), .ARST_N(arst_n), .CE(ce),
    .EVT(evt), .LIN_TX(lin_tx), .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .RD_VALID(rd_valid));
  dfr_host_model host (.CLK(clk), .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .RD_VALID(rd_valid));

  // 100 MHz clock
  always #5 clk = ~clk;

  // expected bytes from event set; reserved bits read zero
  function automatic logic [7:0] exp_low(dfr_pkg::dfr_evt_t v);
    return {v.window_wd_fail, v.remote_wake, 1'b0, v.battery_overvoltage,
      v.overtemp_warning, v.overtemp_reset, v.output_undervoltage, v.supply_power_on};
  endfunction : exp_low
  function automatic logic [7:0] exp_mid(dfr_pkg::dfr_evt_t v);
    return {4'h0, v.load_dump, v.standby_wd_fail, v.thermal_shutdown, 1'b0};
  endfunction : exp_mid

  // one read and compare; a missing answer counts too
  task automatic rdchk(input string name, input logic [7:0] ad, input logic [7:0] ex);
    logic [7:0] d;
    logic       ok;
    host.read(ad, d, ok);
    check_count++;
    if (ok !== 1'b1 || d !== ex)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, ex, d);
    end
  endtask : rdchk

  // event pulse, then wait out the two-stage sync
  task automatic pulse(input dfr_pkg::dfr_evt_t v, input int n);
    @(negedge clk);
    evt = v;
    repeat (n) @(negedge clk);
    evt = '0;
    repeat (4) @(negedge clk);
  endtask : pulse

  task automatic finish_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // watchdog: whole run needs under a thousand cycles
  initial
  begin
    #100us;
    fails++;
    finish_test;
  end

  // main sequence
  initial
  begin
    clk = 0; arst_n = 0; ce = 1; lin_tx = 1; evt = '0;
    seed = 32'h4837; fails = 0; check_count = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    arst_n = 1;
    rdchk("low_rst", dfr_pkg::DIAG_LOW_ADDR, 8'h03);
    rdchk("mid_rst", dfr_pkg::DIAG_MID_ADDR, 8'h00);
    rdchk("low_clr", dfr_pkg::DIAG_LOW_ADDR, 8'h00);
    // single flags walked, then random sets; unmapped read clears nothing
    for (i = 0; i < 34; i++)
    begin
      e = (i < 10) ? dfr_pkg::dfr_evt_t'(10'h1 << i) : dfr_pkg::dfr_evt_t'($random(seed));
      a = 8'($random(seed));
      if (a[7:1] == 7'h04) a[4] = 1'b1;
      pulse(e, 3);
      rdchk("unmapped", a, 8'h00);
      rdchk("low", dfr_pkg::DIAG_LOW_ADDR, exp_low(e));
      rdchk("mid", dfr_pkg::DIAG_MID_ADDR, exp_mid(e));
      rdchk("low_clr", dfr_pkg::DIAG_LOW_ADDR, 8'h00);
      rdchk("mid_clr", dfr_pkg::DIAG_MID_ADDR, 8'h00);
    end
    // held event: read during event leaves flag set
    @(negedge clk);
    evt = '1;
    repeat (4) @(negedge clk);
    rdchk("low_held", dfr_pkg::DIAG_LOW_ADDR, 8'hdf);
    rdchk("low_held", dfr_pkg::DIAG_LOW_ADDR, 8'hdf);
    evt = '0;
    repeat (4) @(negedge clk);
    rdchk("low_stk", dfr_pkg::DIAG_LOW_ADDR, 8'hdf);
    rdchk("mid_stk", dfr_pkg::DIAG_MID_ADDR, 8'h0e);
    rdchk("low_clr", dfr_pkg::DIAG_LOW_ADDR, 8'h00);
    // transmit low: short of the limit, then past it
    @(negedge clk);
    lin_tx = 0;
    repeat (15) @(negedge clk);
    lin_tx = 1;
    rdchk("tx_short", dfr_pkg::DIAG_MID_ADDR, 8'h00);
    @(negedge clk);
    lin_tx = 0;
    repeat (30) @(negedge clk);
    lin_tx = 1;
    repeat (4) @(negedge clk);
    rdchk("tx_stuck", dfr_pkg::DIAG_MID_ADDR, 8'h01);
    rdchk("tx_clr", dfr_pkg::DIAG_MID_ADDR, 8'h00);
    // frozen clock enable misses the event
    ce = 0;
    pulse('1, 3);
    ce = 1;
    rdchk("ce_low", dfr_pkg::DIAG_LOW_ADDR, 8'h00);
    // reset in mid-run restores power-on values
    pulse('1, 3);
    arst_n = 0;
    repeat (2) @(negedge clk);
    arst_n = 1;
    rdchk("low_rst2", dfr_pkg::DIAG_LOW_ADDR, 8'h03);
    rdchk("mid_rst2", dfr_pkg::DIAG_MID_ADDR, 8'h00);
    finish_test;
  end
endmodule : dfr_diag_flags_test

// ---- sim/dfr_host_model.sv ----
`timescale 1ns/100ps
// --------------------------------------------
// microcontroller reading the diagnostic bytes
// --------------------------------------------
module dfr_host_model (
  input  wire logic       CLK,      // system clock
  output logic            RD_EN,    // read strobe
  output logic [7:0]      RD_ADDR,  // read address
  input  wire logic [7:0] RD_DATA,  // read data
  input  wire logic       RD_VALID  // read answer
);
  // idle: no read pending
  initial
  begin
    RD_EN   = 1'b0;
    RD_ADDR = 8'ha5;
  end

  // one strobe per read; each byte read clears it, so host reads both after wakeup
  // address inverted on release so a stale address never looks held
  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(negedge CLK);
    RD_EN   = 1'b1;
    RD_ADDR = addr;
    @(negedge CLK);
    RD_EN   = 1'b0;
    RD_ADDR = ~addr;
    ok      = 1'b0;
    data    = 8'h00;
    for (n = 0; n < 3 && !ok; n++)
    begin
      if (RD_VALID === 1'b1)
      begin
        data = RD_DATA;
        ok   = 1'b1;
      end
      else
        @(negedge CLK);
    end
  endtask : read
endmodule : dfr_host_model
